// *** hw/status_pkg.sv ***
// Shared constants and carriers for the converter status readout
package status_pkg;

  // ==========================================
  // Register addresses (7 bit)
  localparam logic [6:0] ADDR_OVERCURRENT  = 7'h02;
  localparam logic [6:0] ADDR_NEG_OVERCUR  = 7'h03;
  localparam logic [6:0] ADDR_OPER_STATUS  = 7'h04;
  localparam logic [6:0] ADDR_STRAP_ONE    = 7'h05;
  localparam logic [6:0] ADDR_MODE_TWO     = 7'h06;

  // ==========================================
  // Field positions and channel count
  localparam int OPS_SOFT_START_BIT = 2;
  localparam int OPS_MAX_CURRENT_BIT = 1;
  localparam int OPS_IN_WINDOW_BIT   = 0;
  localparam int CFG1_WARN_BIT       = 5;
  localparam int CFG1_GATE_LSB       = 3;
  localparam int CFG1_SENSE_LSB      = 0;
  localparam int CFG2_BURST_BIT      = 4;
  localparam int CFG2_DISC_BIT       = 3;
  localparam int CFG2_HIZ_BIT        = 2;
  localparam int CFG2_SPREAD_BIT     = 1;
  localparam int CFG2_BUCK_BIT       = 0;
  localparam int NUM_CHANNELS        = 6;

  // ==========================================
  // Encodings and values
  localparam logic [1:0] GATE_5V   = 2'h0;
  localparam logic [1:0] GATE_8V   = 2'h1;
  localparam logic [1:0] GATE_10V  = 2'h2;
  localparam logic [2:0] SENSE_10MV = 3'h0;
  localparam logic [2:0] SENSE_50MV = 3'h4;
  localparam logic [7:0] CHECK_INIT = 8'h41;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================
  // Serial frame edge counts
  localparam logic [4:0] CNT_ADDR_DONE  = 5'h08;
  localparam logic [4:0] CNT_CHECK_LATCH = 5'h0F;
  localparam logic [4:0] CNT_FRAME_END  = 5'h18;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [5:0] over_current;
    logic [5:0] reverse_over_current;
    logic       soft_start_done;
    logic       max_current;
    logic       output_in_window;
    logic       burst;
    logic       discontinuous_conduction;
    logic       high_impedance_state;
    logic       spread_spectrum_active;
    logic       buck_direction;
  } status_in_s;

  typedef struct packed {
    logic       set_current_high_warning;
    logic [1:0] gate_supply_level;
    logic [2:0] sense_threshold_code;
  } strap_in_s;

  // Packet check update for one bit, polynomial x^8+x^2+x+1
  function automatic logic [7:0] check_step(input logic [7:0] crc, input logic din);
    logic in0;
    in0 = din ^ crc[7];
    return {crc[6:2], crc[1] ^ in0, crc[0] ^ in0, in0};
  endfunction

endpackage

// *** hw/sync_bits.sv ***
// Two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge mclk) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// *** hw/reg_select.sv ***
// Read-only register map decode for the status group
`timescale 1ns/1ps
module reg_select
  import status_pkg::*;
(
  // Register address
  input  wire logic [6:0] addr,
  // Live status and straps
  input  wire status_in_s status,
  input  wire strap_in_s  straps,
  // Read data
  output logic      [7:0] rdata
);

  // ==========================================
  // Decode
  always_comb begin
    rdata = DATA_RESET;
    case (addr)
      ADDR_OVERCURRENT: rdata = {2'h0, status.over_current};
      ADDR_NEG_OVERCUR: rdata = {2'h0, status.reverse_over_current};
      ADDR_OPER_STATUS: begin
        rdata[OPS_SOFT_START_BIT]  = status.soft_start_done;
        rdata[OPS_MAX_CURRENT_BIT] = status.max_current;
        rdata[OPS_IN_WINDOW_BIT]   = status.output_in_window;
      end
      ADDR_STRAP_ONE: begin
        rdata[CFG1_WARN_BIT]                   = straps.set_current_high_warning;
        rdata[CFG1_GATE_LSB +: 2]              = straps.gate_supply_level;
        rdata[CFG1_SENSE_LSB +: 3]             = straps.sense_threshold_code;
      end
      ADDR_MODE_TWO: begin
        rdata[CFG2_BURST_BIT]  = status.burst;
        rdata[CFG2_DISC_BIT]   = status.discontinuous_conduction;
        rdata[CFG2_HIZ_BIT]    = status.high_impedance_state;
        rdata[CFG2_SPREAD_BIT] = status.spread_spectrum_active;
        rdata[CFG2_BUCK_BIT]   = status.buck_direction;
      end
      default: rdata = DATA_RESET;
    endcase
  end

endmodule

// *** hw/converter_status_readout.sv ***
// Status register group with serial read port and packet check byte
`timescale 1ns/1ps
module converter_status_readout
  import status_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Serial port pins
  input  wire logic       sclk,
  input  wire logic       csb_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // Comparator and controller state pins
  input  wire logic [5:0] chan_over_current,
  input  wire logic [5:0] chan_reverse_over_current,
  input  wire logic       soft_start_done,
  input  wire logic       max_current,
  input  wire logic       output_in_window,
  input  wire logic       burst,
  input  wire logic       discontinuous_conduction,
  input  wire logic       high_impedance_state,
  input  wire logic       spread_spectrum_active,
  input  wire logic       buck_direction,
  // Strap pins
  input  wire logic       set_current_high_warning,
  input  wire logic [1:0] gate_supply_level,
  input  wire logic [2:0] sense_threshold_code
);

  // ==========================================
  // Gather pins into carriers
  status_in_s         status_pins;
  strap_in_s          strap_pins;

  assign status_pins.over_current             = chan_over_current;
  assign status_pins.reverse_over_current     = chan_reverse_over_current;
  assign status_pins.soft_start_done          = soft_start_done;
  assign status_pins.max_current              = max_current;
  assign status_pins.output_in_window         = output_in_window;
  assign status_pins.burst                    = burst;
  assign status_pins.discontinuous_conduction = discontinuous_conduction;
  assign status_pins.high_impedance_state     = high_impedance_state;
  assign status_pins.spread_spectrum_active   = spread_spectrum_active;
  assign status_pins.buck_direction           = buck_direction;
  assign strap_pins.set_current_high_warning  = set_current_high_warning;
  assign strap_pins.gate_supply_level         = gate_supply_level;
  assign strap_pins.sense_threshold_code      = sense_threshold_code;

  // ==========================================
  // Synchronise pins
  localparam int STAT_W  = $bits(status_in_s);
  localparam int STRAP_W = $bits(strap_in_s);

  logic [2:0]         port_sync;
  logic [STAT_W-1:0]  stat_sync;
  logic [STRAP_W-1:0] strap_sync;
  status_in_s         status;
  strap_in_s          straps;

  // Select is inverted so the cleared synchroniser reads as deselected
  sync_bits #(.WIDTH(3)) u_sync_port (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({sclk, ~csb_n, sdi}),
    .sync_out (port_sync)
  );

  sync_bits #(.WIDTH(STAT_W)) u_sync_stat (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (status_pins),
    .sync_out (stat_sync)
  );

  sync_bits #(.WIDTH(STRAP_W)) u_sync_strap (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (strap_pins),
    .sync_out (strap_sync)
  );

  assign status = status_in_s'(stat_sync);
  assign straps = strap_in_s'(strap_sync);

  logic sclk_s;
  logic csb_s;
  logic sdi_s;
  logic sclk_d;
  logic rise;
  logic fall;

  // Serial clock edge toward the given level, inside a selected frame
  function automatic logic sclk_edge(input logic now, input logic prev, input logic sel_n, input logic up);
    return !sel_n && (now != prev) && (now == up);
  endfunction

  assign sclk_s = port_sync[2];
  assign csb_s  = ~port_sync[1];
  assign sdi_s  = port_sync[0];
  assign rise   = sclk_edge(sclk_s, sclk_d, csb_s, 1'b1);
  assign fall   = sclk_edge(sclk_s, sclk_d, csb_s, 1'b0);

  // ==========================================
  // Serial clock history
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // ==========================================
  // Frame state
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_DATA  = 5'b00100,
    ST_CHECK = 5'b01000,
    ST_DONE  = 5'b10000
  } frame_e;

  frame_e     state;
  logic [4:0] edge_cnt;
  logic [7:0] addr_shift;
  logic [7:0] crc;
  logic [7:0] tx_shift;
  logic       is_read;
  logic [7:0] rdata;

  reg_select u_reg_select (
    .addr   (addr_shift[7:1]),
    .status (status),
    .straps (straps),
    .rdata  (rdata)
  );

  // ==========================================
  // Frame phase decode
  logic       addr_bit;
  logic       data_load;
  logic       data_bit;
  logic       check_load;
  logic       shift_out;
  logic       frame_end;
  logic       read_frame;
  logic [7:0] next_check;

  // Rising edge that carries one address or direction bit
  function automatic logic addr_edge(input logic [4:0] cnt);
    return cnt < CNT_ADDR_DONE;
  endfunction

  // Falling edge that moves one sent data bit through the check byte
  function automatic logic data_edge(input logic [4:0] cnt);
    return cnt > CNT_ADDR_DONE && cnt <= CNT_CHECK_LATCH + 5'h01;
  endfunction

  // Falling edge after the last data bit, where the check byte is complete
  function automatic logic check_edge(input logic [4:0] cnt);
    return cnt == CNT_CHECK_LATCH + 5'h01;
  endfunction

  assign addr_bit   = rise && addr_edge(edge_cnt);
  assign data_load  = fall && edge_cnt == CNT_ADDR_DONE;
  assign data_bit   = fall && data_edge(edge_cnt);
  assign check_load = fall && check_edge(edge_cnt);
  assign shift_out  = fall && edge_cnt > CNT_ADDR_DONE;
  assign frame_end  = rise && edge_cnt == CNT_FRAME_END - 5'h01;
  assign read_frame = is_read && (state == ST_DATA || state == ST_CHECK || state == ST_DONE);
  assign next_check = check_step(crc, tx_shift[7]);

  // ==========================================
  // Frame sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!csb_s) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (csb_s) begin
            state <= ST_IDLE;
          end else if (data_load) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (csb_s) begin
            state <= ST_IDLE;
          end else if (check_load) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (csb_s) begin
            state <= ST_IDLE;
          end else if (frame_end) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (csb_s) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Count rising edges in the frame
  always_ff @(posedge mclk) begin
    if (rst || csb_s) begin
      edge_cnt <= 5'h00;
    end else if (rise && edge_cnt != CNT_FRAME_END) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  // ==========================================
  // Address byte and read flag capture
  always_ff @(posedge mclk) begin
    if (rst || csb_s) begin
      addr_shift <= DATA_RESET;
      is_read    <= 1'b0;
    end else if (addr_bit) begin
      addr_shift <= {addr_shift[6:0], sdi_s};
      if (edge_cnt == CNT_ADDR_DONE - 5'h01) begin
        is_read <= sdi_s;
      end
    end
  end

  // ==========================================
  // Check byte over address bits in and data bits out
  always_ff @(posedge mclk) begin
    if (rst || csb_s) begin
      crc <= CHECK_INIT;
    end else if (addr_bit) begin
      crc <= check_step(crc, sdi_s);
    end else if (data_bit) begin
      crc <= next_check;
    end
  end

  // ==========================================
  // Output shifter: data byte, then check byte
  always_ff @(posedge mclk) begin
    if (rst || csb_s) begin
      tx_shift <= DATA_RESET;
    end else if (data_load) begin
      tx_shift <= rdata;
    end else if (check_load) begin
      tx_shift <= next_check;
    end else if (shift_out) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  // ==========================================
  // Read data output, writes never reach the registers
  always_ff @(posedge mclk) begin
    if (rst || csb_s) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (read_frame) begin
      sdo    <= tx_shift[7];
      sdo_oe <= 1'b1;
    end else begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end
  end

endmodule

// *** verification/status_sva.sv ***
// Concurrent checks on the status readout serial port
`timescale 1ns/1ps
module status_sva
  import status_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Serial port
  input wire logic       sclk,
  input wire logic       csb_n,
  input wire logic       sdi,
  input wire logic       sdo,
  input wire logic       sdo_oe,
  // Status and straps
  input wire logic [5:0] chan_over_current,
  input wire logic [5:0] chan_reverse_over_current,
  input wire logic       soft_start_done,
  input wire logic       max_current,
  input wire logic       output_in_window,
  input wire logic       burst,
  input wire logic       discontinuous_conduction,
  input wire logic       high_impedance_state,
  input wire logic       spread_spectrum_active,
  input wire logic       buck_direction,
  input wire logic       set_current_high_warning,
  input wire logic [1:0] gate_supply_level,
  input wire logic [2:0] sense_threshold_code
);
  logic [2:0] sy;
  logic [4:0] cnt;
  logic [7:0] sh;
  logic [7:0] exp_b;
  wire        rise = sy[1] & ~sy[2];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========
  // Frame tracking
  always_ff @(posedge mclk) begin
    sy <= {sy[1:0], sclk};
  end
  always_ff @(posedge mclk) begin
    if (rst || csb_n) begin
      cnt <= 5'h00;
    end else if (rise) begin
      cnt <= cnt + 5'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (rise && cnt < 5'h08) begin
      sh <= {sh[6:0], sdi};
    end
  end
  always_comb begin
    case (sh[7:1])
      ADDR_OVERCURRENT: exp_b = {2'h0, chan_over_current};
      ADDR_NEG_OVERCUR: exp_b = {2'h0, chan_reverse_over_current};
      ADDR_OPER_STATUS: exp_b = {5'h00, soft_start_done, max_current, output_in_window};
      ADDR_STRAP_ONE:   exp_b = {2'h0, set_current_high_warning, gate_supply_level, sense_threshold_code};
      ADDR_MODE_TWO:    exp_b = {3'h0, burst, discontinuous_conduction, high_impedance_state,
                                 spread_spectrum_active, buck_direction};
      default:          exp_b = 8'h00;
    endcase
  end
  // ==========
  // Properties
  sequence data_slot;
    rise && cnt >= 5'h08 && cnt <= 5'h0F && sh[0];
  endsequence
  property data_bit(logic [6:0] a);
    data_slot ##0 (sh[7:1] == a) |-> sdo == exp_b[5'h0F - cnt];
  endproperty
  AST_RST: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !sdo_oe && !sdo)
    else $error("sdo active after reset");
  AST_IDLE: assert property (csb_n [*6] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_WR: assert property (cnt >= 5'h08 && !sh[0] |-> !sdo_oe)
    else $error("sdo driven in write frame");
  AST_RD_OE: assert property (rise && cnt == 5'h08 && sh[0] |-> sdo_oe)
    else $error("sdo not driven in read frame");
  AST_OC: assert property (data_bit(ADDR_OVERCURRENT))
    else $error("overcurrent bit wrong");
  AST_NOC: assert property (data_bit(ADDR_NEG_OVERCUR))
    else $error("reverse overcurrent bit wrong");
  AST_OPS: assert property (data_bit(ADDR_OPER_STATUS))
    else $error("status bit wrong");
  AST_CFG1: assert property (data_bit(ADDR_STRAP_ONE))
    else $error("config one bit wrong");
  AST_CFG2: assert property (data_bit(ADDR_MODE_TWO))
    else $error("config two bit wrong");
  AST_UNMAPPED: assert property (data_slot ##0 (sh[7:1] < 7'h02 || sh[7:1] > 7'h06) |-> !sdo)
    else $error("unmapped read not zero");
endmodule
bind converter_status_readout status_sva chk_u (.*);

// *** verification/spi_master_model.sv ***
// Serial bus master that reads the status registers and sends write frames
`timescale 1ns/1ps
module spi_master_model #(
  parameter int HALF = 6
) (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk,
  output logic      csb_n,
  output logic      sdi,
  input  wire logic sdo_line
);
  function automatic logic [7:0] packet_check_byte(input logic [15:0] v);
    logic [7:0] c;
    logic       b;
    c = 8'h41;
    for (int i = 15; i >= 0; i--) begin
      b = v[i] ^ c[7];
      c = {c[6:2], c[1] ^ b, c[0] ^ b, b};
    end
    return c;
  endfunction
  initial begin
    sclk  = 1'b0;
    csb_n = 1'b1;
    sdi   = 1'b0;
  end
  // ==========
  // One frame: address and direction, data, check byte
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
                      output logic [15:0] rx, output logic ok);
    logic [23:0] tx;
    tx = {a, rd, wd, packet_check_byte({a, rd, wd})};
    @(negedge mclk);
    csb_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      sdi = tx[23 - i];
      repeat (HALF) @(negedge mclk);
      sclk = 1'b1;
      if (i > 7) begin
        rx = {rx[14:0], sdo_line};
      end
      repeat (HALF) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge mclk);
    csb_n = 1'b1;
    sdi   = ~sdi;
    ok    = (packet_check_byte({a, rd, rx[15:8]}) === rx[7:0]);
    repeat (HALF) @(negedge mclk);
  endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the converter status readout
`timescale 1ns/1ps
module testbench;
  import status_pkg::*;
  logic        mclk;
  logic        rst;
  logic        sclk;
  logic        csb_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        ok;
  logic [15:0] rx;
  logic [31:0] seed;
  status_in_s  st;
  strap_in_s   sp;
  int          err_total;
  int          n_checks;
  int          cyc = 0;
  logic [6:0]  addr_tbl [8] = '{ADDR_OVERCURRENT, ADDR_NEG_OVERCUR, ADDR_OPER_STATUS, ADDR_STRAP_ONE,
                                ADDR_MODE_TWO, 7'h01, 7'h07, 7'h7F};
  // Pull-up holds the released line high
  wire         sdo_line = sdo_oe ? sdo : 1'b1;
  converter_status_readout dut_u (
    .mclk(mclk), .rst(rst), .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .chan_over_current(st.over_current), .chan_reverse_over_current(st.reverse_over_current),
    .soft_start_done(st.soft_start_done), .max_current(st.max_current),
    .output_in_window(st.output_in_window), .burst(st.burst),
    .discontinuous_conduction(st.discontinuous_conduction), .high_impedance_state(st.high_impedance_state),
    .spread_spectrum_active(st.spread_spectrum_active), .buck_direction(st.buck_direction),
    .set_current_high_warning(sp.set_current_high_warning), .gate_supply_level(sp.gate_supply_level),
    .sense_threshold_code(sp.sense_threshold_code)
  );
  spi_master_model master_u (.mclk(mclk), .sclk(sclk), .csb_n(csb_n), .sdi(sdi), .sdo_line(sdo_line));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] exp_reg(input logic [6:0] a, input status_in_s s, input strap_in_s p);
    case (a)
      ADDR_OVERCURRENT: return {2'h0, s.over_current};
      ADDR_NEG_OVERCUR: return {2'h0, s.reverse_over_current};
      ADDR_OPER_STATUS: return {5'h00, s[7:5]};
      ADDR_STRAP_ONE:   return {2'h0, p};
      ADDR_MODE_TWO:    return {3'h0, s[4:0]};
      default:          return 8'h00;
    endcase
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    n_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ==========
  // Main sequence: corner pass with status all ones and straps at 10V and 50mV codes, then random levels
  initial begin
    rst = 1'b1;
    st = '0;
    sp = '0;
    seed = 32'hCC10;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 48; i++) begin
      seed = lfsr_next(seed);
      st = (i < 8) ? '1 : status_in_s'(seed[19:0]);
      sp = (i < 8) ? {1'b1, GATE_10V, SENSE_50MV} : {seed[20], 2'(seed[22:21] % 3), 3'(seed[25:23] % 5)};
      repeat (4) @(negedge mclk);
      master_u.xfer(addr_tbl[i % 8], (i % 6) != 5, seed[31:24], rx, ok);
      if ((i % 6) != 5) begin
        check("read data", rx[15:8], exp_reg(addr_tbl[i % 8], st, sp));
        check("check byte", {7'h00, ok}, 8'h01);
      end else begin
        check("write frame line", rx[15:8], 8'hFF);
      end
    end
    tally_and_finish();
  end
endmodule
